// ---- tb/host_link_model.sv ----
// translator-board model for the clocked scheme: shifts on the target's clock, paces by handshake
// assumes sclk comes from the target and is sampled in the mclk domain
`timescale 1ns/1ns
module host_link_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sdo,
    input wire logic [7:0] reply,
    input wire logic [15:0] hs_delay,
    output logic sdi,
    output logic hs,
    output logic [7:0] got
);
    logic sclk_d = 1'b0;
    logic waiting = 1'b0;
    logic [2:0] rises = 3'h0;
    logic [2:0] falls = 3'h0;
    logic [15:0] hs_cnt = 16'h0000;
    initial hs = 1'b0;
    initial got = 8'h00;
    // msb first, next bit presented after each clock fall
    assign sdi = reply[3'h7 - falls];
    always @(posedge mclk) begin
        sclk_d <= sclk;
        if (rst) begin
            rises <= 3'h0;
            falls <= 3'h0;
            hs <= 1'b0;
            waiting <= 1'b0;
        end else if (sclk && !sclk_d) begin
            got <= {got[6:0], sdo};
            rises <= rises + 3'h1;
            hs <= 1'b0;
            if (rises == 3'h7) begin
                waiting <= 1'b1;
                hs_cnt <= 16'h0000;
            end
        end else begin
            if (!sclk && sclk_d) begin
                falls <= falls + 3'h1;
            end
            // ready for more only after a slow, adjustable delay
            if (waiting) begin
                hs_cnt <= hs_cnt + 16'h0001;
                if (hs_cnt == hs_delay) begin
                    hs <= 1'b1;
                    waiting <= 1'b0;
                end
            end
        end
    end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the programming port link
// assumes the design files under verilog/ and the translator model beside this file
`timescale 1ns/1ns
module tb;
    localparam int DIV = 2;
    localparam int PACE = 4;
    logic mclk = 0, rst = 1, strap_low = 0, strap_high = 0, loop_en = 0, host_dtr_reset = 0;
    logic breakpoint_hit = 0, attn_clear = 0, cold_boot_en = 0, bit6_wr = 0, bit6_lvl = 0;
    logic cable_probe = 0, async_tx = 0, alt_en = 0, pace_hs = 0, tx_valid = 0, p_tick = 0;
    logic rxa_valid = 0;
    logic [7:0] tx_data = 8'h00, rxa_byte = 8'h00, reply = 8'h00;
    logic [15:0] hs_delay = 16'h0000;
    logic boot_low, boot_high, sdi, hs, reset_req, present, tx_pin, status_pin, rx_pu, clk_pu;
    logic programming_connector_lead_mode, normal_ok, tx_ready, rx_valid, host_attn, bios_restart, dbl_ok;
    logic [7:0] rx_data, baud_div, got;
    int failures = 0;
    int checked = 0;
    assign boot_low = alt_en ? hs : strap_low;
    assign boot_high = loop_en ? tx_pin : strap_high;
    programming_port_link #(.SHIFT_DIV(DIV), .PACE_CYCLES(PACE)) i_programming_port_link (
        .mclk(mclk), .rst(rst), .boot_select_pin_low(boot_low), .boot_select_pin_high(boot_high),
        .host_dtr_reset(host_dtr_reset), .target_reset_req(reset_req),
        .breakpoint_hit(breakpoint_hit), .attn_clear(attn_clear), .cold_boot_en(cold_boot_en),
        .port_c_bit6_write(bit6_wr), .port_c_bit6_level(bit6_lvl), .cable_probe(cable_probe),
        .cable_present(present), .serial_a_transmit_pin(tx_pin), .serial_a_async_tx(async_tx),
        .port_c_bit7_pin(sdi), .status_pin(status_pin), .serial_a_receive_pin_pullup(rx_pu),
        .serial_a_clock_pin_pullup(clk_pu), .programming_mode(programming_connector_lead_mode),
        .normal_startup_ok(normal_ok), .alt_scheme_en(alt_en), .pace_by_handshake(pace_hs),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .periodic_tick(p_tick), .host_attn_req(host_attn),
        .rx_async_byte(rxa_byte), .rx_async_valid(rxa_valid), .bios_restart(bios_restart),
        .baud_divisor(baud_div), .doubler_allowed(dbl_ok));
    host_link_model i_host_link_model (.mclk(mclk), .rst(rst || !alt_en), .sclk(status_pin),
        .sdo(tx_pin), .reply(reply), .hs_delay(hs_delay), .sdi(sdi), .hs(hs), .got(got));
    initial begin
        forever #2 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic do_reset(input logic sl, input logic sh);
        @(posedge mclk) begin
            rst <= 1;
            strap_low <= sl;
            strap_high <= sh;
        end
        repeat (8) @(posedge mclk);
        #1 check({rx_pu, clk_pu}, 2'h3);
        check({tx_pin, status_pin}, 2'h0);
        @(posedge mclk) rst <= 0;
        repeat (2) @(posedge mclk);
        #1 check(programming_connector_lead_mode, sl & sh);
        check(normal_ok, !sl & !sh);
        check(baud_div, 8'h08);
        check(dbl_ok, 1'b1);
    endtask
    task automatic t_straps_fwd();
        for (int i = 0; i < 4; i++) do_reset(i[0], i[1]);
        @(posedge mclk) host_dtr_reset <= 1;
        #1 check(reset_req, 1'b0);
        @(posedge mclk) host_dtr_reset <= 0;
        #1 check(reset_req, 1'b1);
    endtask
    task automatic t_attention();
        @(posedge mclk) breakpoint_hit <= 1;
        @(posedge mclk) attn_clear <= 1;
        #1 check(status_pin, 1'b1);
        @(posedge mclk) breakpoint_hit <= 0;
        #1 check(status_pin, 1'b1);
        @(posedge mclk) attn_clear <= 0;
        #1 check(status_pin, 1'b0);
    endtask
    task automatic probe(input logic lp, input logic exp);
        @(posedge mclk) begin
            bit6_wr <= 1;
            bit6_lvl <= 0;
            loop_en <= lp;
        end
        @(posedge mclk) bit6_wr <= 0;
        #1 check(tx_pin, 1'b0);
        @(posedge mclk) cable_probe <= 1;
        @(posedge mclk) cable_probe <= 0;
        #1 check(tx_pin, 1'b1);
        @(posedge mclk) #1 check(present, exp);
    endtask
    task automatic t_probe();
        @(posedge mclk) begin
            cold_boot_en <= 1;
            async_tx <= 1;
            strap_high <= 0;
        end
        @(posedge mclk) #1 check(tx_pin, 1'b1);
        @(posedge mclk) cold_boot_en <= 0;
        probe(1'b1, 1'b1);
        probe(1'b0, 1'b0);
    endtask
    task automatic t_restart();
        logic [31:0] seq [3];
        logic hit [3];
        seq = '{32'h0080_2480, 32'h8080_2480, 32'h0080_2580};
        hit = '{1'b1, 1'b1, 1'b0};
        @(posedge mclk) host_dtr_reset <= 1;
        @(posedge mclk) host_dtr_reset <= 0;
        #1 check(reset_req, 1'b1);
        repeat (4) @(posedge mclk);
        #1 check(reset_req, 1'b0);
        for (int s = 0; s < 3; s++) begin
            for (int b = 3; b >= 0; b--) begin
                @(posedge mclk) begin
                    rxa_byte <= seq[s][8*b +: 8];
                    rxa_valid <= 1;
                end
                @(posedge mclk) rxa_valid <= 0;
            end
            #1 check(bios_restart, hit[s]);
            @(posedge mclk) #1 check(bios_restart, 1'b0);
        end
    endtask
    task automatic t_shift(input logic [7:0] d, input logic [7:0] r, input logic h, input int dly);
        int n;
        n = 0;
        @(posedge mclk) begin
            pace_hs <= h;
            hs_delay <= dly[15:0];
            reply <= r;
        end
        #1;
        while (tx_ready !== 1'b1 && n < 1000) @(posedge mclk) #1 n++;
        check(tx_ready, 1'b1);
        @(posedge mclk) begin
            tx_data <= d;
            tx_valid <= 1;
        end
        @(posedge mclk) tx_valid <= 0;
        n = 0;
        #1;
        check(tx_ready, 1'b0);
        while (rx_valid !== 1'b1 && n < 1000) @(posedge mclk) #1 n++;
        check(rx_data, r);
        check(got, d);
        check(tx_ready, 1'b1);
        if (h) check(n >= 14 * DIV + dly + 4 && n <= 15 * DIV + dly + 3, 1'b1);
        else check(n >= 15 * DIV + PACE + 1 && n <= 16 * DIV + PACE, 1'b1);
    endtask
    task automatic t_host_attn();
        @(posedge mclk) strap_high <= 1;
        repeat (3) @(posedge mclk);
        #1 check(host_attn, 1'b0);
        @(posedge mclk) p_tick <= 1;
        @(posedge mclk) p_tick <= 0;
        #1 check(host_attn, 1'b1);
    endtask
    initial begin
        #100000;
        failures++;
        close_out();
    end
    initial begin
        t_straps_fwd();
        t_attention();
        t_probe();
        t_restart();
        @(posedge mclk) alt_en <= 1;
        t_shift(8'hA5, 8'h3C, 1'b0, 0);
        t_shift(8'h01, 8'h80, 1'b1, 40);
        t_shift(8'hFE, 8'h7F, 1'b1, 40);
        t_host_attn();
        close_out();
    end
endmodule

// ---- verilog/clocked_shifter.sv ----
// target-clocked byte shifter for the alternate port scheme
// assumes tick is a one-cycle enable from a divider and rst is synchronous
`timescale 1ns/1ns
`include "programming_connector_lead_port_defines.svh"
module clocked_shifter #(
    parameter int PACE_CYCLES = `PACE_CYCLES_DEFAULT
) (
    input wire logic mclk,
    input wire logic rst,
    shift_link_if.shifter lk
);
    programming_connector_lead_port_pkg::shift_state_t state_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] tx_sh_r;
    logic [7:0] rx_sh_r;
    logic [15:0] pace_cnt_r;
    logic pace_done;
    logic sclk_r;
    logic sdo_r;
    logic [7:0] rx_data_r;
    logic rx_valid_r;

    // a byte is released only on handshake or after the agreed delay
    assign pace_done = lk.hs_mode ? lk.handshake
                                  : (pace_cnt_r == 16'(PACE_CYCLES - 1));
    assign lk.tx_ready = (state_r == programming_connector_lead_port_pkg::SH_IDLE);
    assign lk.sclk = sclk_r;
    assign lk.sdo = sdo_r;
    assign lk.rx_data = rx_data_r;
    assign lk.rx_valid = rx_valid_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= programming_connector_lead_port_pkg::SH_IDLE;
        end else begin
            unique case (state_r)
                programming_connector_lead_port_pkg::SH_IDLE: begin
                    if (lk.tx_valid) begin
                        state_r <= programming_connector_lead_port_pkg::SH_SHIFT;
                    end
                end
                programming_connector_lead_port_pkg::SH_SHIFT: begin
                    if (lk.tick && sclk_r && bit_cnt_r == `BYTE_LAST_BIT) begin
                        state_r <= programming_connector_lead_port_pkg::SH_PACE;
                    end
                end
                programming_connector_lead_port_pkg::SH_PACE: begin
                    if (pace_done) begin
                        state_r <= programming_connector_lead_port_pkg::SH_IDLE;
                    end
                end
                default: state_r <= programming_connector_lead_port_pkg::SH_IDLE;
            endcase
        end
    end

    // target drives the shift clock; data changes low, is sampled on the rise
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclk_r <= 1'b0;
            sdo_r <= 1'b0;
            bit_cnt_r <= 3'h0;
            tx_sh_r <= 8'h00;
            rx_sh_r <= 8'h00;
        end else if (state_r == programming_connector_lead_port_pkg::SH_IDLE && lk.tx_valid) begin
            tx_sh_r <= lk.tx_data;
            sdo_r <= lk.tx_data[7];
            bit_cnt_r <= 3'h0;
            sclk_r <= 1'b0;
        end else if (state_r == programming_connector_lead_port_pkg::SH_SHIFT && lk.tick) begin
            sclk_r <= ~sclk_r;
            if (!sclk_r) begin
                rx_sh_r <= {rx_sh_r[6:0], lk.sdi};
            end else if (bit_cnt_r != `BYTE_LAST_BIT) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                sdo_r <= tx_sh_r[6];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || state_r != programming_connector_lead_port_pkg::SH_PACE) begin
            pace_cnt_r <= 16'h0000;
        end else if (!pace_done) begin
            pace_cnt_r <= pace_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_data_r <= 8'h00;
            rx_valid_r <= 1'b0;
        end else begin
            rx_valid_r <= (state_r == programming_connector_lead_port_pkg::SH_PACE) && pace_done;
            if (state_r == programming_connector_lead_port_pkg::SH_PACE && pace_done) begin
                rx_data_r <= rx_sh_r;
            end
        end
    end

    AST_SCLK_ON_TICK: assert property (@(posedge mclk) disable iff (rst)
        $changed(sclk_r) |-> $past(lk.tick))
        else $error("shift clock moved without a divider tick");
    AST_SDO_HELD_HIGH: assert property (@(posedge mclk) disable iff (rst)
        sclk_r && $past(sclk_r) |-> $stable(sdo_r))
        else $error("data out changed while shift clock high");
    AST_HS_GATES_NEXT: assert property (@(posedge mclk) disable iff (rst)
        $rose(lk.tx_ready) && $past(lk.hs_mode) |-> $past(lk.handshake))
        else $error("next byte released without handshake");
    AST_PACE_DELAY: assert property (@(posedge mclk) disable iff (rst)
        $rose(lk.tx_ready) && !$past(lk.hs_mode) |-> $past(pace_cnt_r) == 16'(PACE_CYCLES - 1))
        else $error("pacing delay cut short");
endmodule

// ---- verilog/programming_connector_lead_port_defines.svh ----
// constants for the programming port link: boot-pin codes, restart bytes, clock figures
// assumes inclusion by bare name from design files that need them
`ifndef PROGRAMMING_CONNECTOR_LEAD_PORT_DEFINES_SVH
`define PROGRAMMING_CONNECTOR_LEAD_PORT_DEFINES_SVH
`define BOOT_BOTH_HIGH 2'h3
`define BOOT_BOTH_LOW 2'h0
`define BIOS_RESTART_B0 8'h80
`define BIOS_RESTART_B1 8'h24
`define BIOS_RESTART_B2 8'h80
`define BAUD_REF_HZ 921600
`define DOUBLER_MAX_KHZ 27000
`define MCLK_PERIOD_NS 4
`define SHIFT_DIV_DEFAULT 16
`define PACE_CYCLES_DEFAULT 64
`define BYTE_LAST_BIT 3'h7
`endif

// ---- verilog/programming_connector_lead_port_pkg.sv ----
// types for the programming port link
// assumes nothing beyond the defines header
package programming_connector_lead_port_pkg;
    typedef enum logic [2:0] {
        SH_IDLE  = 3'b001,
        SH_SHIFT = 3'b010,
        SH_PACE  = 3'b100
    } shift_state_t;
    typedef enum logic [1:0] {
        RS_WAIT_B0 = 2'b01,
        RS_WAIT_B1 = 2'b10
    } restart_seen_t;
endpackage

// ---- verilog/programming_port_link.sv ----
// top of the target-side programming and diagnostic port
// assumes all pins synchronous to mclk and a synchronous active-high rst
// What this block does
// - Outside the alternate scheme the target raises its status line at a breakpoint so the host sees it on DSR.
// - Both boot-mode pins high at firmware start mean the cable is in: enter programming mode.
// - Normal start-up happens only when both boot-mode pins are held low.
// - With cold boot off, the serial-A transmit pin (port C bit 6) drives zero after reset.
// - Cable presence is probed by raising port C bit 6 and reading a looped-back boot-mode pin.
// - In the alternate scheme port C bits 6 and 7 are data out and in, clocked by the status pin.
// - In the alternate scheme the target waits for a handshake level or a set delay per byte.
// - Serial-A receive and clock inputs are pulled up so a floating cable gives no data.
// - The halved crystal with doubler is allowed only up to a 27 MHz operating clock.
// - The 115,200 baud divisor is the doubled clock frequency divided by 921,600.
`timescale 1ns/1ns
`include "programming_connector_lead_port_defines.svh"
module programming_port_link #(
    parameter int SHIFT_DIV = `SHIFT_DIV_DEFAULT,
    parameter int PACE_CYCLES = `PACE_CYCLES_DEFAULT,
    parameter int OPER_CLK_HZ = 7372800
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic boot_select_pin_low,
    input wire logic boot_select_pin_high,
    input wire logic host_dtr_reset,
    output logic target_reset_req,
    input wire logic breakpoint_hit,
    input wire logic attn_clear,
    input wire logic cold_boot_en,
    input wire logic port_c_bit6_write,
    input wire logic port_c_bit6_level,
    input wire logic cable_probe,
    output logic cable_present,
    output logic serial_a_transmit_pin,
    input wire logic serial_a_async_tx,
    input wire logic port_c_bit7_pin,
    output logic status_pin,
    output logic serial_a_receive_pin_pullup,
    output logic serial_a_clock_pin_pullup,
    output logic programming_mode,
    output logic normal_startup_ok,
    input wire logic alt_scheme_en,
    input wire logic pace_by_handshake,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic periodic_tick,
    output logic host_attn_req,
    input wire logic [7:0] rx_async_byte,
    input wire logic rx_async_valid,
    output logic bios_restart,
    output logic [7:0] baud_divisor,
    output logic doubler_allowed
);
    // the operating clock already is the doubled frequency
    localparam int BAUD_DIV = OPER_CLK_HZ / `BAUD_REF_HZ;
    localparam bit DOUBLER_OK = (OPER_CLK_HZ / 1000) <= `DOUBLER_MAX_KHZ;

    shift_link_if lk ();

    logic [1:0] boot_pins_r;
    logic boot_cap_r;
    logic programming_connector_lead_mode_r;
    logic normal_ok_r;
    logic attn_r;
    logic pc6_r;
    logic probe_r;
    logic cable_r;
    logic host_attn_r;
    logic reset_req_r;
    logic bios_restart_r;
    logic [1:0] seen_r;
    logic [7:0] baud_div_r;
    logic doubler_r;
    logic [15:0] div_cnt_r;
    logic tick_r;

    // boot-mode straps are caught on the first clock after reset release
    always_ff @(posedge mclk) begin
        if (rst) begin
            boot_cap_r <= 1'b0;
            boot_pins_r <= 2'h0;
            programming_connector_lead_mode_r <= 1'b0;
            normal_ok_r <= 1'b0;
        end else if (!boot_cap_r) begin
            boot_cap_r <= 1'b1;
            boot_pins_r <= {boot_select_pin_high, boot_select_pin_low};
            programming_connector_lead_mode_r <= {boot_select_pin_high, boot_select_pin_low} == `BOOT_BOTH_HIGH;
            normal_ok_r <= {boot_select_pin_high, boot_select_pin_low} == `BOOT_BOTH_LOW;
        end
    end

    // host reset arrives as a plain level on the DTR lead
    always_ff @(posedge mclk) begin
        if (rst) begin
            reset_req_r <= 1'b0;
        end else begin
            reset_req_r <= host_dtr_reset;
        end
    end

    // breakpoint attention is sticky; a new hit wins over a clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            attn_r <= 1'b0;
        end else if (breakpoint_hit) begin
            attn_r <= 1'b1;
        end else if (attn_clear) begin
            attn_r <= 1'b0;
        end
    end

    // port C bit 6 latch and loop-back cable probe
    always_ff @(posedge mclk) begin
        if (rst) begin
            pc6_r <= 1'b0;
            probe_r <= 1'b0;
            cable_r <= 1'b0;
        end else begin
            probe_r <= cable_probe && !cold_boot_en && !alt_scheme_en;
            if (cable_probe && !cold_boot_en && !alt_scheme_en) begin
                pc6_r <= 1'b1;
            end else if (port_c_bit6_write) begin
                pc6_r <= port_c_bit6_level;
            end
            if (probe_r) begin
                cable_r <= boot_select_pin_high;
            end
        end
    end

    // divider for the target-driven shift clock
    always_ff @(posedge mclk) begin
        if (rst || !alt_scheme_en) begin
            div_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else if (div_cnt_r == 16'(SHIFT_DIV - 1)) begin
            div_cnt_r <= 16'h0000;
            tick_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // host attention in the alternate scheme, looked at only on the periodic tick
    always_ff @(posedge mclk) begin
        if (rst) begin
            host_attn_r <= 1'b0;
        end else if (periodic_tick) begin
            host_attn_r <= alt_scheme_en && boot_select_pin_high;
        end
    end

    // boot-firmware restart string watcher on the async receive stream
    always_ff @(posedge mclk) begin
        if (rst) begin
            seen_r <= 2'h0;
            bios_restart_r <= 1'b0;
        end else begin
            bios_restart_r <= 1'b0;
            if (rx_async_valid) begin
                if (seen_r == programming_connector_lead_port_pkg::RS_WAIT_B1 && rx_async_byte == `BIOS_RESTART_B2) begin
                    bios_restart_r <= 1'b1;
                    seen_r <= 2'h0;
                end else if (seen_r == programming_connector_lead_port_pkg::RS_WAIT_B0
                             && rx_async_byte == `BIOS_RESTART_B1) begin
                    seen_r <= programming_connector_lead_port_pkg::RS_WAIT_B1;
                end else if (rx_async_byte == `BIOS_RESTART_B0) begin
                    seen_r <= programming_connector_lead_port_pkg::RS_WAIT_B0;
                end else begin
                    seen_r <= 2'h0;
                end
            end
        end
    end

    // clock-plan figures held for the boot firmware to read
    always_ff @(posedge mclk) begin
        if (rst) begin
            baud_div_r <= 8'h00;
            doubler_r <= 1'b0;
        end else begin
            baud_div_r <= 8'(BAUD_DIV);
            doubler_r <= DOUBLER_OK;
        end
    end

    assign lk.tick = tick_r;
    assign lk.tx_data = tx_data;
    assign lk.tx_valid = tx_valid && alt_scheme_en;
    assign lk.sdi = port_c_bit7_pin;
    assign lk.handshake = boot_select_pin_low;
    assign lk.hs_mode = pace_by_handshake;

    clocked_shifter #(
        .PACE_CYCLES(PACE_CYCLES)
    ) u_shifter (
        .mclk(mclk),
        .rst(rst),
        .lk(lk)
    );

    assign tx_ready = lk.tx_ready && alt_scheme_en;
    assign rx_data = lk.rx_data;
    assign rx_valid = lk.rx_valid;
    assign status_pin = alt_scheme_en ? lk.sclk : attn_r;
    assign serial_a_transmit_pin = cold_boot_en ? serial_a_async_tx
                                 : (alt_scheme_en ? lk.sdo : pc6_r);
    assign serial_a_receive_pin_pullup = 1'b1;
    assign serial_a_clock_pin_pullup = 1'b1;
    assign target_reset_req = reset_req_r;
    assign cable_present = cable_r;
    assign programming_mode = programming_connector_lead_mode_r;
    assign normal_startup_ok = normal_ok_r;
    assign host_attn_req = host_attn_r;
    assign bios_restart = bios_restart_r;
    assign baud_divisor = baud_div_r;
    assign doubler_allowed = doubler_r;

    AST_STATUS_ON_BRK: assert property (@(posedge mclk) disable iff (rst)
        breakpoint_hit && !alt_scheme_en ##1 !alt_scheme_en |-> status_pin)
        else $error("status not raised after breakpoint");
    AST_PROGRAMMING_CONNECTOR_LEAD_ON_HIGH: assert property (@(posedge mclk) disable iff (rst)
        !boot_cap_r && boot_select_pin_high && boot_select_pin_low |=> programming_mode[*3])
        else $error("programming mode missed with both boot pins high");
    AST_NORMAL_ONLY_LOW: assert property (@(posedge mclk) disable iff (rst)
        normal_startup_ok |-> boot_pins_r == `BOOT_BOTH_LOW && !programming_mode)
        else $error("normal start-up without both boot pins low");
    AST_TX_ZERO_AFTER_RST: assert property (@(posedge mclk) disable iff (rst)
        $past(rst) && !cold_boot_en |-> !serial_a_transmit_pin)
        else $error("transmit pin not zero after reset");
    AST_CABLE_PROBE: assert property (@(posedge mclk) disable iff (rst)
        cable_probe && !cold_boot_en && !alt_scheme_en
        |=> (serial_a_transmit_pin || cold_boot_en || alt_scheme_en)
        ##1 cable_present == $past(boot_select_pin_high))
        else $error("cable probe did not raise bit 6 and read boot pin");
    AST_ATTN_ON_TICK: assert property (@(posedge mclk) disable iff (rst)
        $rose(host_attn_req) |-> $past(periodic_tick) && $past(boot_select_pin_high))
        else $error("host attention not taken on periodic tick");
    AST_BIOS_STRING: assert property (@(posedge mclk) disable iff (rst)
        bios_restart |-> $past(rx_async_valid) && $past(rx_async_byte) == `BIOS_RESTART_B2)
        else $error("boot restart without closing byte");
    AST_BAUD_DIV: assert property (@(posedge mclk) disable iff (rst)
        !$past(rst) |-> baud_divisor == 8'(OPER_CLK_HZ / `BAUD_REF_HZ))
        else $error("baud divisor wrong");
endmodule

// ---- verilog/shift_link_if.sv ----
// carrier between the port top and its clocked serial shifter
// assumes both ends run on mclk
`timescale 1ns/1ns
interface shift_link_if;
    logic tick;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    logic [7:0] rx_data;
    logic rx_valid;
    logic sclk;
    logic sdo;
    logic sdi;
    logic handshake;
    logic hs_mode;
    modport top (output tick, tx_data, tx_valid, sdi, handshake, hs_mode,
                 input tx_ready, rx_data, rx_valid, sclk, sdo);
    modport shifter (input tick, tx_data, tx_valid, sdi, handshake, hs_mode,
                     output tx_ready, rx_data, rx_valid, sclk, sdo);
endinterface
